// file: core/bstp_pkg.sv
package bstp_pkg;
  localparam int unsigned IR_W = 10;
  localparam int unsigned UCODE_W = 32;
  localparam int unsigned BSR_SMALL = 1029;
  localparam int unsigned BSR_MEDIUM = 1665;
  localparam int unsigned BSR_LARGE = 1941;
  localparam int unsigned CELLS_PER_PIN = 3;
  localparam int unsigned WORD_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  // Identification fields; values arbitrary
  localparam logic [3:0] ID_VERSION = 4'h3;
  localparam logic [15:0] ID_PART = 16'h5a5a;
  localparam logic [10:0] ID_MAKER = 11'h155;
  localparam logic [UCODE_W-1:0] USERCODE_RST = 32'h0000_0000;
  // Instruction opcodes
  localparam logic [IR_W-1:0] OP_EXTEST = 10'h000;
  localparam logic [IR_W-1:0] OP_PULSE = 10'h001;
  localparam logic [IR_W-1:0] OP_ICR = 10'h002;
  localparam logic [IR_W-1:0] OP_SAMPLE = 10'h005;
  localparam logic [IR_W-1:0] OP_IDCODE = 10'h006;
  localparam logic [IR_W-1:0] OP_USERCODE = 10'h007;
  localparam logic [IR_W-1:0] OP_CLAMP = 10'h00a;
  localparam logic [IR_W-1:0] OP_HIGHZ = 10'h00b;
  localparam logic [IR_W-1:0] OP_CONFIG_IO = 10'h00d;
  localparam logic [IR_W-1:0] OP_LA = 10'h00e;
  localparam logic [IR_W-1:0] OP_BYPASS = 10'h3ff;
  localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;
  localparam logic [IR_W-1:0] IR_RST = OP_IDCODE;

  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008, TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020,
    TAP_PA_DR = 16'h0040, TAP_EX2_DR = 16'h0080, TAP_UP_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PA_IR = 16'h2000, TAP_EX2_IR = 16'h4000,
    TAP_UP_IR = 16'h8000
  } bstp_tap_e;

  typedef enum logic [2:0] {
    DR_BYP = 3'h0, DR_BSR = 3'h1, DR_ID = 3'h2, DR_UC = 3'h3,
    DR_STD = 3'h4, DR_LA = 3'h5, DR_ICR = 3'h6
  } bstp_dr_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bstp_link_s;

  typedef struct packed {
    logic busy;
    logic done;
  } bstp_cfg_s;
endpackage : bstp_pkg

// file: core/bstp_top.sv
`timescale 1ns/100ps
module bstp_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  import bstp_pkg::*;
  localparam int unsigned AW = $clog2(D);
  initial
  begin
    if (D < 2 || (1 << AW) != D) $error("bstp_fifo depth must be a power of two");
  end
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } bstp_fifo_s;
  bstp_fifo_s q, d;
  logic full, empty;
  assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign empty = q.wp == q.rp;
  assign wr_ready = !full;
  assign rd_valid = !empty;
  assign rd_data = q.mem[q.rp[AW-1:0]];
  always_comb
  begin
    d = q;
    if (wr_valid && !full)
    begin
      d.mem[q.wp[AW-1:0]] = wr_data;
      d.wp = q.wp + 1'b1;
    end
    if (rd_ready && !empty)
      d.rp = q.rp + 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end
endmodule : bstp_fifo

module bstp_top #(
  parameter int unsigned BSR_LEN = bstp_pkg::BSR_SMALL,
  parameter int unsigned NPIN = 64,
  parameter int unsigned PLL_BITS = 32,
  parameter int unsigned STD_W = 4,
  parameter int unsigned LA_W = 16,
  parameter logic [31:0] USERCODE = bstp_pkg::USERCODE_RST
) (
  input wire logic clk,
  input wire logic rst,
  input wire bstp_pkg::bstp_link_s link,
  output logic tdo,
  output logic tdo_oe_n,
  input wire bstp_pkg::bstp_cfg_s cfg,
  input wire logic [NPIN-1:0] user_out,
  input wire logic [NPIN-1:0] user_oe_n,
  input wire logic [NPIN-1:0] keep_en,
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe_n,
  output logic [NPIN-1:0] pin_hold,
  output logic [NPIN*STD_W-1:0] io_std,
  output logic [PLL_BITS-1:0] pll_cfg,
  output logic reconfig_pulse_instruction,
  output logic cfg_stop,
  input wire logic [LA_W-1:0] la_probe,
  output logic [LA_W-1:0] la_ctrl,
  output logic [bstp_pkg::WORD_W-1:0] cfg_data,
  output logic cfg_valid,
  input wire logic cfg_ready,
  output logic icr_overrun
);
  import bstp_pkg::*;
  initial
  begin
    if (!(BSR_LEN inside {BSR_SMALL, BSR_MEDIUM, BSR_LARGE})) $error("bstp_top bad chain length");
    if (NPIN * CELLS_PER_PIN > BSR_LEN) $error("bstp_top too many pins for chain");
    if (PLL_BITS < 1 || STD_W < 1 || LA_W < 1) $error("bstp_top zero width");
  end

  // ****************************************
  // Controller next state and DR decode
  // ****************************************
  function automatic bstp_tap_e tap_next(bstp_tap_e s, logic tms);
    unique case (s)
      TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UP_DR : TAP_PA_DR;
      TAP_PA_DR: tap_next = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UP_DR : TAP_SH_DR;
      TAP_UP_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UP_IR : TAP_PA_IR;
      TAP_PA_IR: tap_next = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UP_IR : TAP_SH_IR;
      TAP_UP_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default: tap_next = TAP_RESET;
    endcase
  endfunction : tap_next

  function automatic bstp_dr_e dr_sel(logic [IR_W-1:0] ir);
    unique case (ir)
      OP_EXTEST, OP_SAMPLE: dr_sel = DR_BSR;
      OP_IDCODE: dr_sel = DR_ID;
      OP_USERCODE: dr_sel = DR_UC;
      OP_CONFIG_IO: dr_sel = DR_STD;
      OP_LA: dr_sel = DR_LA;
      OP_ICR: dr_sel = DR_ICR;
      default: dr_sel = DR_BYP;
    endcase
  endfunction : dr_sel

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    bstp_link_s s1;
    bstp_link_s s2;
    logic tck_prev;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    bstp_tap_e tap;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic byp;
    logic [UCODE_W-1:0] dr32;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [BSR_LEN-1:0] bsr_up;
    logic [PLL_BITS-1:0] pll_sh;
    logic [PLL_BITS-1:0] pll_up;
    logic [NPIN*STD_W-1:0] std_sh;
    logic [NPIN*STD_W-1:0] std_up;
    logic [LA_W-1:0] la_sh;
    logic [LA_W-1:0] la_up;
    logic [WORD_W-1:0] word;
    logic [2:0] bcnt;
    logic push;
    logic ovr;
    logic tdo;
    logic tdo_oe_n;
    logic [NPIN-1:0] pin_out;
    logic [NPIN-1:0] pin_oe_n;
    logic [NPIN-1:0] pin_hold;
    logic reconf;
    logic stop;
  } bstp_state_s;
  bstp_state_s q, d;

  logic rise, fall, fifo_ready, drive_bsr, float_all, pll_in;
  bstp_dr_e sel;
  assign rise = q.s2.tck && !q.tck_prev;
  assign fall = !q.s2.tck && q.tck_prev;
  assign sel = dr_sel(q.ir);
  assign pll_in = !cfg.done;
  assign drive_bsr = (q.ir == OP_EXTEST || q.ir == OP_CLAMP) && !cfg.busy;
  assign float_all = q.ir == OP_HIGHZ && !cfg.busy;

  bstp_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .wr_valid(q.push),
    .wr_ready(fifo_ready),
    .wr_data(q.word),
    .rd_valid(cfg_valid),
    .rd_ready(cfg_ready),
    .rd_data(cfg_data)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    d = q;
    d.s1 = link;
    d.s2 = q.s1;
    d.tck_prev = q.s2.tck;
    d.pin_s1 = pin_in;
    d.pin_s2 = q.pin_s1;
    d.push = 1'b0;
    d.reconf = 1'b0;
    d.stop = 1'b0;
    if (rise)
    begin
      d.tap = tap_next(q.tap, q.s2.tms);
      unique case (q.tap)
        TAP_RESET: d.ir = IR_RST;
        TAP_CAP_IR: d.ir_sh = IR_CAPTURE;
        TAP_SH_IR: d.ir_sh = {q.s2.tdi, q.ir_sh[IR_W-1:1]};
        TAP_UP_IR:
        begin
          d.ir = q.ir_sh;
          d.stop = q.ir_sh == OP_CONFIG_IO && cfg.busy;
        end
        TAP_CAP_DR:
        begin
          d.byp = 1'b0;
          d.bcnt = 3'h0;
          unique case (sel)
            DR_ID: d.dr32 = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
            DR_UC: d.dr32 = USERCODE;
            DR_STD: d.std_sh = q.std_up;
            DR_LA: d.la_sh = la_probe;
            DR_BSR:
            begin
              for (int i = 0; i < NPIN; i++)
              begin
                d.bsr_sh[CELLS_PER_PIN*i] = q.pin_s2[i];
                d.bsr_sh[CELLS_PER_PIN*i+1] = q.pin_out[i];
                d.bsr_sh[CELLS_PER_PIN*i+2] = !q.pin_oe_n[i];
              end
              if (pll_in)
                d.pll_sh = q.pll_up;
            end
            default: d.byp = 1'b0;
          endcase
        end
        TAP_SH_DR:
        begin
          unique case (sel)
            DR_ID, DR_UC: d.dr32 = {q.s2.tdi, q.dr32[UCODE_W-1:1]};
            DR_STD: d.std_sh = {q.s2.tdi, q.std_sh[NPIN*STD_W-1:1]};
            DR_LA: d.la_sh = {q.s2.tdi, q.la_sh[LA_W-1:1]};
            DR_BSR:
            begin
              d.bsr_sh = {pll_in ? q.pll_sh[0] : q.s2.tdi, q.bsr_sh[BSR_LEN-1:1]};
              if (pll_in)
                d.pll_sh = {q.s2.tdi, q.pll_sh[PLL_BITS-1:1]};
            end
            DR_ICR:
            begin
              d.byp = q.s2.tdi;
              if (fifo_ready)
              begin
                d.word = {q.s2.tdi, q.word[WORD_W-1:1]};
                d.bcnt = q.bcnt + 3'h1;
                d.push = q.bcnt == 3'h7;
              end
              else
                d.ovr = 1'b1;
            end
            default: d.byp = q.s2.tdi;
          endcase
        end
        TAP_UP_DR:
        begin
          unique case (sel)
            DR_STD: d.std_up = q.std_sh;
            DR_LA: d.la_up = q.la_sh;
            DR_BSR:
            begin
              d.bsr_up = q.bsr_sh;
              if (pll_in)
                d.pll_up = q.pll_sh;
            end
            default: d.byp = q.byp;
          endcase
        end
        default: d.byp = q.byp;
      endcase
      d.reconf = d.ir == OP_PULSE && d.tap == TAP_IDLE && q.tap != TAP_IDLE;
    end
    if (fall)
    begin
      d.tdo_oe_n = !(q.tap == TAP_SH_DR || q.tap == TAP_SH_IR);
      if (q.tap == TAP_SH_IR)
        d.tdo = q.ir_sh[0];
      else
        unique case (sel)
          DR_ID, DR_UC: d.tdo = q.dr32[0];
          DR_STD: d.tdo = q.std_sh[0];
          DR_LA: d.tdo = q.la_sh[0];
          DR_BSR: d.tdo = q.bsr_sh[0];
          default: d.tdo = q.byp;
        endcase
    end
    for (int i = 0; i < NPIN; i++)
    begin
      d.pin_out[i] = drive_bsr ? q.bsr_up[CELLS_PER_PIN*i+1] : !float_all && user_out[i];
      d.pin_oe_n[i] = drive_bsr ? !q.bsr_up[CELLS_PER_PIN*i+2] : float_all || user_oe_n[i];
      d.pin_hold[i] = keep_en[i] && d.pin_oe_n[i] && (drive_bsr || float_all);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.tap <= TAP_RESET;
      q.ir <= IR_RST;
      q.tdo_oe_n <= 1'b1;
      q.pin_oe_n <= '1;
    end
    else
      q <= d;
  end

  assign tdo = q.tdo;
  assign tdo_oe_n = q.tdo_oe_n;
  assign pin_out = q.pin_out;
  assign pin_oe_n = q.pin_oe_n;
  assign pin_hold = q.pin_hold;
  assign io_std = q.std_up;
  assign pll_cfg = q.pll_up;
  assign reconfig_pulse_instruction = q.reconf;
  assign cfg_stop = q.stop;
  assign la_ctrl = q.la_up;
  assign icr_overrun = q.ovr;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_rise_in(bstp_tap_e st);
    rise && q.tap == st;
  endsequence

  a_tdo_float: assert property (@(posedge clk) disable iff (rst)
    fall && q.tap != TAP_SH_DR && q.tap != TAP_SH_IR |=> tdo_oe_n)
    else $error("tdo driven outside shift");
  a_reset_idcode: assert property (@(posedge clk) disable iff (rst)
    s_rise_in(TAP_RESET) |=> q.ir == OP_IDCODE)
    else $error("reset did not select id");
  a_id_lsb_one: assert property (@(posedge clk) disable iff (rst)
    s_rise_in(TAP_CAP_DR) ##0 sel == DR_ID |=> q.dr32[0] && q.dr32[31:28] == ID_VERSION)
    else $error("id capture wrong");
  a_bypass_bit: assert property (@(posedge clk) disable iff (rst)
    s_rise_in(TAP_SH_DR) ##0 sel == DR_BYP |=> q.byp == $past(q.s2.tdi))
    else $error("bypass bit not loaded");
  a_highz_pins: assert property (@(posedge clk) disable iff (rst)
    q.ir == OP_HIGHZ && !cfg.busy |=> &pin_oe_n)
    else $error("pins driven under highz");
  a_busy_no_test: assert property (@(posedge clk) disable iff (rst)
    cfg.busy |=> pin_oe_n == $past(user_oe_n))
    else $error("test drove pins during configuration");
  a_pll_frozen: assert property (@(posedge clk) disable iff (rst)
    cfg.done ##1 cfg.done |-> $stable(pll_cfg))
    else $error("pll bits changed after configuration");
  a_reconfig_pulse: assert property (@(posedge clk) disable iff (rst)
    reconfig_pulse_instruction |=> !reconfig_pulse_instruction)
    else $error("reconfig pulse too long");
  a_cfg_stop_set: assert property (@(posedge clk) disable iff (rst)
    s_rise_in(TAP_UP_IR) ##0 q.ir_sh == OP_CONFIG_IO && cfg.busy |=> cfg_stop)
    else $error("config stop missed");
  a_hold_override: assert property (@(posedge clk) disable iff (rst)
    float_all && keep_en[0] ##1 float_all |-> pin_hold[0])
    else $error("bus hold not applied");
endmodule : bstp_top

// file: dv/bstp_host.sv
`timescale 1ns/100ps
module bstp_host (
  input wire logic clk,
  output bstp_pkg::bstp_link_s link,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  import bstp_pkg::*;
  // ****************************************
  // Test host: one TCK cycle is 16 clk
  // ****************************************
  initial
  begin
    link = '0;
  end

  // Released tdo reads inverted
  task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
    link.tck = 1'b0;
    link.tms = tms_v;
    link.tdi = tdi_v;
    repeat (8) @(negedge clk);
    tdo_v = tdo_oe_n ? ~tdo : tdo;
    link.tck = 1'b1;
    repeat (8) @(negedge clk);
  endtask : step

  // Idle tdi toggles each cycle
  task automatic walks(input logic [3:0] seq, input int n);
    logic b;
    for (int i = 0; i < n; i++)
      step(seq[i], ~link.tdi, b);
  endtask : walks

  task automatic walk(input logic tms_v);
    walks({3'b000, tms_v}, 1);
  endtask : walk

  task automatic reset_tap();
    walks(4'b1111, 4);
    walks(4'b0001, 2);
  endtask : reset_tap

  // Shift LSB first, then Update and Idle
  task automatic shift(input int n, input logic [1279:0] din, output logic [1279:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], dout[i]);
    walks(4'b0001, 2);
  endtask : shift

  task automatic shift_ir(input logic [IR_W-1:0] op, output logic [IR_W-1:0] cap);
    logic [1279:0] d;
    walks(4'b0011, 4);
    shift(IR_W, {1270'h0, op}, d);
    cap = d[IR_W-1:0];
  endtask : shift_ir

  task automatic shift_dr(input int n, input logic [1279:0] din, output logic [1279:0] dout);
    walks(4'b0001, 3);
    shift(n, din, dout);
  endtask : shift_dr
endmodule : bstp_host

// file: dv/bstp_top_tb.sv
`timescale 1ns/100ps
module bstp_top_tb;
  import bstp_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  localparam int unsigned BSR = BSR_SMALL;
  localparam int unsigned PLL = 32;
  localparam int unsigned NP = 64;
  localparam logic [31:0] UC = 32'h1234_abcd;
  localparam logic [63:0] PO = 64'hdead_beef_0bad_f00d;
  localparam logic [63:0] POE_N = 64'h0f0f_0f0f_0f0f_0f0f;
  localparam logic [31:0] PV = 32'h5a3c_0ff1;
  logic clk;
  logic rst;
  bstp_link_s link;
  bstp_cfg_s cfg;
  logic tdo, tdo_oe_n, pulse, cfg_stop, cfg_valid, cfg_ready, icr_overrun;
  logic [NP-1:0] user_out, user_oe_n, keep_en, pin_in, pin_out, pin_oe_n, pin_hold;
  logic [NP*4-1:0] io_std;
  logic [PLL-1:0] pll_cfg;
  logic [15:0] la_probe, la_ctrl;
  logic [WORD_W-1:0] cfg_data;
  logic [1279:0] dout;
  logic [IR_W-1:0] cap;
  int n_mismatch, compares, n_pulse, n_stop;

  bstp_top #(.BSR_LEN(BSR), .NPIN(NP), .PLL_BITS(PLL), .STD_W(4), .LA_W(16), .USERCODE(UC)) DUT (
    .clk(clk), .rst(rst), .link(link), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .cfg(cfg),
    .user_out(user_out), .user_oe_n(user_oe_n), .keep_en(keep_en), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_hold(pin_hold), .io_std(io_std),
    .pll_cfg(pll_cfg), .reconfig_pulse_instruction(pulse), .cfg_stop(cfg_stop),
    .la_probe(la_probe), .la_ctrl(la_ctrl), .cfg_data(cfg_data), .cfg_valid(cfg_valid),
    .cfg_ready(cfg_ready), .icr_overrun(icr_overrun)
  );
  bstp_host host (.clk(clk), .link(link), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (pulse === 1'b1)
      n_pulse++;
    if (cfg_stop === 1'b1)
      n_stop++;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic complete_run();
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [255:0] exp, input logic [255:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic ir(input logic [IR_W-1:0] op);
    host.shift_ir(op, cap);
  endtask : ir

  task automatic dr(input int n, input logic [1279:0] din);
    host.shift_dr(n, din, dout);
  endtask : dr
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_idcode();
    host.reset_tap();
    ir(OP_BYPASS);
    chk("ir_capture", 256'(IR_CAPTURE), 256'(cap));
    host.reset_tap();
    dr(32, '0);
    chk("idcode", {ID_VERSION, ID_PART, ID_MAKER, 1'b1}, dout[31:0]);
  endtask : t_idcode

  task automatic t_usercode();
    ir(OP_USERCODE);
    dr(64, {32'hc0de_5eed, 32'h0000_0000});
    chk("usercode", UC, dout[31:0]);
    chk("usercode_len", 32'h0000_0000, dout[63:32]);
  endtask : t_usercode

  task automatic t_bypass(input logic [IR_W-1:0] op);
    ir(op);
    dr(8, 8'hc3);
    chk("bypass_path", 8'h86, dout[7:0]);
  endtask : t_bypass

  task automatic t_scan();
    logic [1279:0] din;
    logic [191:0] exp;
    din = '0;
    exp = '0;
    for (int i = 0; i < NP; i++)
    begin
      din[8 + 3 * i + 1] = PO[i];
      din[8 + 3 * i + 2] = ~POE_N[i];
      exp[3 * i +: 3] = {~user_oe_n[i], user_out[i], pin_in[i]};
    end
    din[7:0] = 8'h5a;
    din[8 + BSR +: PLL] = PV;
    ir(OP_SAMPLE);
    dr(BSR + PLL + 8, din);
    chk("pll_cfg", PV, pll_cfg);
    chk("sample_capture", exp, dout[191:0]);
    chk("chain_with_pll", 8'h5a, dout[BSR+PLL +: 8]);
    cfg.done = 1'b1;
    ir(OP_EXTEST);
    chk("extest_out", PO, pin_out);
    chk("extest_oe", POE_N, pin_oe_n);
    chk("extest_hold", keep_en & POE_N, pin_hold);
    pin_in = ~pin_in;
    dr(BSR + 8, din);
    for (int i = 0; i < NP; i++)
      chk("extest_capture", pin_in[i], dout[3 * i]);
    chk("chain_no_pll", 8'h5a, dout[BSR +: 8]);
    chk("pll_frozen", PV, pll_cfg);
  endtask : t_scan

  task automatic t_clamp_highz();
    t_bypass(OP_CLAMP);
    chk("clamp_out", PO, pin_out);
    chk("clamp_oe", POE_N, pin_oe_n);
    t_bypass(OP_HIGHZ);
    chk("highz_oe", {NP{1'b1}}, pin_oe_n);
    chk("highz_hold", keep_en, pin_hold);
    cfg.busy = 1'b1;
    cfg.done = 1'b0;
    host.walk(1'b0);
    chk("busy_oe", user_oe_n, pin_oe_n);
    chk("busy_out", user_out, pin_out);
  endtask : t_clamp_highz

  task automatic t_config_io();
    ir(OP_CONFIG_IO);
    chk("stop_busy", 1, n_stop);
    cfg.busy = 1'b0;
    cfg.done = 1'b1;
    ir(OP_CONFIG_IO);
    chk("stop_done", 1, n_stop);
    dr(256, {4{PO}});
    chk("io_std", {4{PO}}, io_std);
  endtask : t_config_io

  task automatic t_pulse_la();
    chk("no_pulse", 0, n_pulse);
    ir(OP_PULSE);
    chk("pulse", 1, n_pulse);
    ir(OP_LA);
    dr(16, 16'h71b2);
    chk("la_capture", la_probe, dout[15:0]);
    chk("la_ctrl", 16'h71b2, la_ctrl);
  endtask : t_pulse_la

  // Far side stalls until full, then drains
  task automatic t_icr();
    logic [1279:0] din;
    din = '0;
    for (int k = 0; k < 9; k++)
      din[8 * k +: 8] = 8'h31 + 8'(k);
    chk("overrun_idle", 1'b0, icr_overrun);
    ir(OP_ICR);
    dr(65, din);
    chk("overrun_full", 1'b1, icr_overrun);
    for (int k = 0; k < 8; k++)
    begin
      for (int w = 0; cfg_valid !== 1'b1; w++)
        if (w == 20)
        begin
          n_mismatch++;
          complete_run();
        end
        else
          @(negedge clk);
      chk("icr_byte", 8'h31 + 8'(k), cfg_data);
      cfg_ready = 1'b1;
      @(negedge clk);
      cfg_ready = 1'b0;
    end
    repeat (2) @(negedge clk);
    chk("fifo_empty", 1'b0, cfg_valid);
  endtask : t_icr
  // ****************************************
  // Run
  // ****************************************
  initial
  begin
    rst = 1'b1;
    cfg = '0;
    cfg_ready = 1'b0;
    user_out = 64'hf0f0_1234_5678_9abc;
    user_oe_n = 64'h00ff_00ff_00ff_00ff;
    keep_en = 64'h0000_ffff_0000_ffff;
    pin_in = 64'h0123_4567_89ab_cdef;
    la_probe = 16'h9c3e;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("pin_oe_n_reset", {NP{1'b1}}, pin_oe_n);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("tdo_oe_n_reset", 1'b1, tdo_oe_n);
    chk("pin_oe_n_user", user_oe_n, pin_oe_n);
    t_idcode();
    t_usercode();
    t_bypass(OP_BYPASS);
    t_bypass(10'h155);
    t_scan();
    t_clamp_highz();
    t_config_io();
    t_pulse_la();
    t_icr();
    complete_run();
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule : bstp_top_tb
